// *** verilog/d3i_consts.svh ***
// Mode register select codes, field positions and timing counts for the DDR3 init block
`ifndef D3I_CONSTS_SVH
`define D3I_CONSTS_SVH

// Mode register select codes on the bank bits
`define D3I_SEL_BURST_LATENCY 3'h0
`define D3I_SEL_DLL_DRIVE 3'h1
`define D3I_SEL_WRITE_LATENCY 3'h2
`define D3I_SEL_EXTRA_FEATURE 3'h3

// Field positions in the burst latency mode register; chop select and long calibration are command address bits
`define D3I_BL_LO 0
`define D3I_BL_HI 1
`define D3I_BURST_TYPE_BIT 3
`define D3I_DLL_RESET_BIT 8
`define D3I_CHOP_SEL_BIT 12
`define D3I_CAL_LONG_BIT 10

// Burst length field encodings
`define D3I_BL_FIXED8 2'h0
`define D3I_BL_ON_FLY 2'h1
`define D3I_BL_FIXED4 2'h2

// Reset values
`define D3I_MODE_RST 15'h0000
`define D3I_BANK_MASK_RST 4'h0

// Wait counts in clock cycles
`define D3I_DLL_LOCK_CYC 512
`define D3I_CAL_INIT_CYC 512

`endif

// *** verilog/d3i_pkg.sv ***
// Types shared by the DDR3 init block
package d3i_pkg;

    typedef enum logic [1:0] {
        D3I_WAIT_CKE = 2'b00,
        D3I_PROGRAM = 2'b01,
        D3I_CALIBRATE = 2'b10,
        D3I_READY = 2'b11
    } d3i_state_t;

    typedef enum logic [2:0] {
        D3I_CMD_NONE = 3'b000,
        D3I_CMD_MODE_SET = 3'b001,
        D3I_CMD_CAL = 3'b010,
        D3I_CMD_READ = 3'b011,
        D3I_CMD_WRITE = 3'b100,
        D3I_CMD_OTHER = 3'b101
    } d3i_cmd_t;

endpackage

// *** verilog/d3i_burst_seq.sv ***
// Beat order sequencer for one read or write burst
`timescale 1ns/1ns
`include "d3i_consts.svh"

module d3i_burst_seq
    import d3i_pkg::*;
(
    input wire logic core_clk, // Device clock
    input wire logic rst_n, // Reset, active low
    input wire logic start, // Burst command accepted
    input wire logic is_write, // Command is a write
    input wire logic chop, // Burst chopped to four
    input wire logic interleave, // Interleaved beat order
    input wire logic [2:0] start_col, // Start column bits 2..0
    output logic beat_valid_q, // Beat slot active
    output logic beat_drive_q, // Data driven in this slot
    output logic [2:0] beat_index_q // Beat index within burst
);

    logic [2:0] cnt_q;
    logic busy_q;
    logic wr_q;
    logic chop_q;
    logic il_q;
    logic [2:0] col_q;

    // Beat index for a given beat count
    function automatic logic [2:0] beat_of(input logic wr, input logic ch, input logic il,
                                           input logic [2:0] col, input logic [2:0] n);
        logic [1:0] low;
        low = col[1:0] + n[1:0];
        if (wr)
        begin
            beat_of = ch ? {col[2], n[1:0]} : n;
        end
        else if (il)
        begin
            beat_of = col ^ n;
        end
        else
        begin
            beat_of = {col[2] ^ n[2], low};
        end
    endfunction

    wire logic [2:0] cur_cnt = start ? 3'h0 : cnt_q;
    wire logic cur_wr = start ? is_write : wr_q;
    wire logic cur_ch = start ? chop : chop_q;
    wire logic cur_il = start ? interleave : il_q;
    wire logic [2:0] cur_col = start ? start_col : col_q;
    wire logic active = start | busy_q;

    // Burst capture and beat counting
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 3'h0;
            busy_q <= 1'b0;
            wr_q <= 1'b0;
            chop_q <= 1'b0;
            il_q <= 1'b0;
            col_q <= 3'h0;
        end
        else
        begin
            if (start)
            begin
                wr_q <= is_write;
                chop_q <= chop;
                il_q <= interleave;
                col_q <= start_col;
            end
            busy_q <= active && (cur_cnt != 3'h7);
            cnt_q <= active ? cur_cnt + 3'h1 : 3'h0;
        end
    end

    // Registered beat outputs
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            beat_valid_q <= 1'b0;
            beat_drive_q <= 1'b0;
            beat_index_q <= 3'h0;
        end
        else
        begin
            beat_valid_q <= active;
            beat_drive_q <= active && !(cur_ch && cur_cnt[2]);
            beat_index_q <= beat_of(cur_wr, cur_ch, cur_il, cur_col, cur_cnt);
        end
    end

endmodule

// *** verilog/d3i_init_core.sv ***
// Device-side DDR3 init tracking, mode registers and termination gating
//
// Behaviour
// - Termination stays off in reset and until clock enable is first registered high.
// - Mode registers reset to zero; each must be written before use.
// - Mode sets and DLL reset never touch array contents.
// - Mode register zero is selected with all command and bank bits low.
// - Register zero bit 3 selects sequential or interleaved beat order.
// - Register zero bits 1..0 select chopped, eight-beat or on-the-fly bursts.
// - Sequential reads wrap within the nibble; chopped reads tri-state last four.
// - Interleaved reads XOR start column; writes ignore low column bits.
`timescale 1ns/1ns
`include "d3i_consts.svh"

module d3i_init_core
    import d3i_pkg::*;
#(
    parameter int DLL_LOCK_CYC = `D3I_DLL_LOCK_CYC,
    parameter int CAL_INIT_CYC = `D3I_CAL_INIT_CYC
)
(
    input wire logic core_clk, // Device clock
    input wire logic rst_n, // Reset pin, active low
    input wire logic cke, // Clock enable
    input wire logic cs_n, // Chip select, active low
    input wire logic ras_n, // Row strobe, active low
    input wire logic cas_n, // Column strobe, active low
    input wire logic we_n, // Write enable, active low
    input wire logic [2:0] bank, // Bank bits two..zero
    input wire logic [14:0] addr, // Address bits
    input wire logic termination_input, // Termination request
    output logic termination_on_q, // On-die termination active
    output logic init_done_q, // Ready for normal operation
    output logic [3:0] mode_written_q, // Mode registers written since reset
    output logic [14:0] burst_latency_mode_q, // Mode register zero
    output logic [14:0] dll_drive_mode_q, // Mode register one
    output logic [14:0] write_latency_mode_q, // Mode register two
    output logic [14:0] extra_feature_mode_q, // Mode register three
    output logic dll_locked_q, // DLL lock wait expired
    output logic beat_valid_q, // Burst beat slot active
    output logic beat_drive_q, // Burst beat data driven
    output logic [2:0] beat_index_q // Burst beat index
);

    localparam int CNT_W = 16;

    d3i_state_t state_q;
    d3i_state_t state_d;
    logic cke_seen_q;
    logic [CNT_W-1:0] dll_cnt_q;
    logic [CNT_W-1:0] cal_cnt_q;
    logic cal_started_q;

    // Command class of the pins; idle unless clock enable and chip select are active
    function automatic d3i_cmd_t decode_cmd(input logic en, input logic [3:0] pins,
                                            input logic cal_flag);
        if (!en || pins[3])
        begin
            decode_cmd = D3I_CMD_NONE;
        end
        else
        begin
            case (pins[2:0])
                3'b000: decode_cmd = D3I_CMD_MODE_SET;
                3'b110: decode_cmd = cal_flag ? D3I_CMD_CAL : D3I_CMD_OTHER;
                3'b101: decode_cmd = D3I_CMD_READ;
                3'b100: decode_cmd = D3I_CMD_WRITE;
                3'b111: decode_cmd = D3I_CMD_NONE;
                default: decode_cmd = D3I_CMD_OTHER;
            endcase
        end
    endfunction

    // Command decode while the clock enable pin is high
    wire d3i_cmd_t cmd_kind = decode_cmd(cke, {cs_n, ras_n, cas_n, we_n},
                                         addr[`D3I_CAL_LONG_BIT]);
    wire logic cmd_mode_set = (cmd_kind == D3I_CMD_MODE_SET);
    wire logic cmd_cal = (cmd_kind == D3I_CMD_CAL);
    wire logic cmd_read = (cmd_kind == D3I_CMD_READ);
    wire logic cmd_write = (cmd_kind == D3I_CMD_WRITE);

    // Mode register select
    wire logic sel_burst = cmd_mode_set && (bank == `D3I_SEL_BURST_LATENCY);
    wire logic sel_dll = cmd_mode_set && (bank == `D3I_SEL_DLL_DRIVE);
    wire logic sel_wlat = cmd_mode_set && (bank == `D3I_SEL_WRITE_LATENCY);
    wire logic sel_extra = cmd_mode_set && (bank == `D3I_SEL_EXTRA_FEATURE);
    wire logic dll_reset_req = sel_burst && addr[`D3I_DLL_RESET_BIT];

    // All four mode registers written since reset; bursts and ready wait on it
    wire logic all_written = (mode_written_q == 4'hf);

    // Burst length and type from mode register zero
    wire logic [1:0] bl_field = burst_latency_mode_q[`D3I_BL_HI:`D3I_BL_LO];
    wire logic burst_chop = (bl_field == `D3I_BL_FIXED4) ||
                            ((bl_field == `D3I_BL_ON_FLY) && !addr[`D3I_CHOP_SEL_BIT]);
    wire logic burst_il = burst_latency_mode_q[`D3I_BURST_TYPE_BIT];
    wire logic burst_start = (state_q == D3I_READY) && (cmd_read || cmd_write) &&
                             all_written;

    wire logic dll_done = (dll_cnt_q == '0);
    wire logic cal_done = cal_started_q && (cal_cnt_q == '0);

    // Init sequence tracking
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            D3I_WAIT_CKE:
                if (cke)
                    state_d = D3I_PROGRAM;
            D3I_PROGRAM:
                if (cmd_cal)
                    state_d = D3I_CALIBRATE;
            D3I_CALIBRATE:
                if (dll_done && cal_done && all_written)
                    state_d = D3I_READY;
            D3I_READY:
                state_d = D3I_READY;
            default:
                state_d = D3I_WAIT_CKE;
        endcase
    end

    // State, clock enable seen and termination gating
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= D3I_WAIT_CKE;
            cke_seen_q <= 1'b0;
            termination_on_q <= 1'b0;
            init_done_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cke_seen_q <= cke_seen_q | cke;
            termination_on_q <= (cke_seen_q | cke) && termination_input;
            init_done_q <= (state_d == D3I_READY);
        end
    end

    // Mode register writes replace the whole register; register zero stores the DLL reset bit as zero
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            burst_latency_mode_q <= `D3I_MODE_RST;
            dll_drive_mode_q <= `D3I_MODE_RST;
            write_latency_mode_q <= `D3I_MODE_RST;
            extra_feature_mode_q <= `D3I_MODE_RST;
            mode_written_q <= `D3I_BANK_MASK_RST;
        end
        else
        begin
            if (sel_burst)
                burst_latency_mode_q <= addr & ~(15'h1 << `D3I_DLL_RESET_BIT);
            if (sel_dll)
                dll_drive_mode_q <= addr;
            if (sel_wlat)
                write_latency_mode_q <= addr;
            if (sel_extra)
                extra_feature_mode_q <= addr;
            mode_written_q <= mode_written_q | {sel_extra, sel_wlat, sel_dll, sel_burst};
        end
    end

    // DLL lock and calibration countdowns
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dll_cnt_q <= CNT_W'(DLL_LOCK_CYC);
            cal_cnt_q <= CNT_W'(CAL_INIT_CYC);
            cal_started_q <= 1'b0;
            dll_locked_q <= 1'b0;
        end
        else
        begin
            if (dll_reset_req)
                dll_cnt_q <= CNT_W'(DLL_LOCK_CYC);
            else if (!dll_done)
                dll_cnt_q <= dll_cnt_q - 16'h0001;
            if (cmd_cal)
            begin
                cal_cnt_q <= CNT_W'(CAL_INIT_CYC);
                cal_started_q <= 1'b1;
            end
            else if (cal_started_q && !cal_done)
                cal_cnt_q <= cal_cnt_q - 16'h0001;
            dll_locked_q <= dll_done && !dll_reset_req;
        end
    end

    // Burst beat ordering; no array state is touched by mode sets
    d3i_burst_seq u_burst
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(burst_start),
        .is_write(cmd_write),
        .chop(burst_chop),
        .interleave(burst_il),
        .start_col(addr[2:0]),
        .beat_valid_q(beat_valid_q),
        .beat_drive_q(beat_drive_q),
        .beat_index_q(beat_index_q)
    );

endmodule

// *** tb/d3i_init_core_properties.sv ***
// Port-level checks on the DDR3 init core
`timescale 1ns/1ns
module d3i_init_core_properties (
    input wire logic core_clk, // Device clock
    input wire logic rst_n, // Reset, active low
    input wire logic cke, // Clock enable
    input wire logic cs_n, // Chip select
    input wire logic ras_n, // Row strobe
    input wire logic cas_n, // Column strobe
    input wire logic we_n, // Write enable
    input wire logic [2:0] bank, // Bank bits
    input wire logic [14:0] addr, // Address
    input wire logic termination_input, // Termination request
    input wire logic termination_on_q, // Termination active
    input wire logic init_done_q, // Ready
    input wire logic [3:0] mode_written_q, // Written flags
    input wire logic [14:0] burst_latency_mode_q, // Register zero
    input wire logic [14:0] write_latency_mode_q, // Register two
    input wire logic dll_locked_q, // DLL wait over
    input wire logic beat_valid_q, // Beat slot
    input wire logic beat_drive_q, // Beat driven
    input wire logic [2:0] beat_index_q // Beat index
);
    logic cke_seen_q;
    // Command decodes
    wire mode_set = cke && !cs_n && !ras_n && !cas_n && !we_n;
    wire go = cke && !cs_n && ras_n && !cas_n && init_done_q && (&mode_written_q);
    wire [1:0] bl = burst_latency_mode_q[1:0];
    wire chop = (bl == 2'h2) || (bl == 2'h1 && !addr[12]);
    // Clock enable seen since reset
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n)
            cke_seen_q <= 1'b0;
        else if (cke)
            cke_seen_q <= 1'b1;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_eight_slots;
        beat_valid_q [*8];
    endsequence
    sequence s_chop_quiet;
        ##5 (!beat_drive_q) [*4];
    endsequence
    a_mode_zero_store: assert property (mode_set && bank == 3'h0 |=>
        burst_latency_mode_q == ($past(addr) & 15'h7eff) && mode_written_q[0]) else $error("mode zero");
    a_mode_two_store: assert property (mode_set && bank == 3'h2 |=>
        write_latency_mode_q == $past(addr) && mode_written_q[2]) else $error("mode two");
    a_term_gate_off: assert property (!cke_seen_q && !cke |=> !termination_on_q)
        else $error("termination before clock enable");
    a_term_follows: assert property (cke && termination_input |=> termination_on_q)
        else $error("termination not on");
    a_dll_relock: assert property (mode_set && bank == 3'h0 && addr[8] |=> !dll_locked_q)
        else $error("dll lock kept");
    a_done_needs_all: assert property ($rose(init_done_q) |-> (&mode_written_q) && dll_locked_q)
        else $error("ready too early");
    a_burst_eight_slots: assert property (go |=> s_eight_slots)
        else $error("slot count");
    a_read_first_beat: assert property (go && we_n |=> beat_index_q == $past(addr[2:0]))
        else $error("first read beat");
    a_inter_last_beat: assert property (go && we_n && burst_latency_mode_q[3] && !chop |->
        ##8 beat_index_q == ($past(addr[2:0], 8) ^ 3'h7)) else $error("interleaved last beat");
    a_chop_tristate: assert property (go && chop |-> s_chop_quiet)
        else $error("chopped beats driven");
endmodule
bind d3i_init_core d3i_init_core_properties u_props (.core_clk(core_clk), .rst_n(rst_n),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank(bank),
    .addr(addr), .termination_input(termination_input), .termination_on_q(termination_on_q),
    .init_done_q(init_done_q), .mode_written_q(mode_written_q),
    .burst_latency_mode_q(burst_latency_mode_q), .write_latency_mode_q(write_latency_mode_q),
    .dll_locked_q(dll_locked_q), .beat_valid_q(beat_valid_q), .beat_drive_q(beat_drive_q),
    .beat_index_q(beat_index_q));

// *** tb/d3i_ctrl_model.sv ***
// Controller model issuing init and burst commands
`timescale 1ns/1ns
module d3i_ctrl_model #(
    parameter int GAP = 4,
    parameter int XPR = 5
)
(
    input wire logic core_clk, // Device clock
    output logic cke, // Clock enable
    output logic cs_n, // Chip select
    output logic ras_n, // Row strobe
    output logic cas_n, // Column strobe
    output logic we_n, // Write enable
    output logic [2:0] bank, // Bank bits
    output logic [14:0] addr, // Address
    output logic termination_input // Termination request
);
    // Deselected bus at time zero, termination left high before clock enable
    initial
    begin
        cke = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        bank = 3'h0;
        addr = 15'h0000;
        termination_input = 1'b1;
    end
    // One command after the spacing gap, then deselect with scrambled address
    task cmd(input logic [3:0] pins, input logic [2:0] b, input logic [14:0] a);
        repeat (GAP) @(posedge core_clk);
        #1;
        {cs_n, ras_n, cas_n, we_n} = pins;
        bank = b;
        addr = a;
        @(posedge core_clk);
        #1;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        bank = ~b;
        addr = ~a;
    endtask
    // Power-up programming order
    task init_seq(input logic [14:0] mr1, input logic [14:0] mr0);
        @(posedge core_clk);
        #1;
        termination_input = 1'b0;
        cke = 1'b1;
        repeat (XPR) @(posedge core_clk);
        cmd(4'h0, 3'h2, 15'h0008);
        cmd(4'h0, 3'h3, 15'h0003);
        cmd(4'h0, 3'h1, mr1);
        cmd(4'h0, 3'h0, mr0);
        cmd(4'h6, 3'h0, 15'h0400);
    endtask
endmodule

// *** tb/test_ddr3_init_and_mode_setup.sv ***
// Self-checking bench for the DDR3 init core
`timescale 1ns/1ns
module test_ddr3_init_and_mode_setup;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cke, cs_n, ras_n, cas_n, we_n, termination_input, termination_on_q, init_done_q;
    logic dll_locked_q, beat_valid_q, beat_drive_q;
    logic [2:0] bank, beat_index_q;
    logic [3:0] mode_written_q;
    logic [14:0] addr, mr0_q, mr1_q, mr2_q, mr3_q;
    logic [27:0] r;
    int err_count = 0;
    int comparisons = 0;
    // Mode nibble, write, chop select, column, first beat, fifth beat, fifth driven
    logic [27:0] rows [7] = '{28'h0005511, 28'h8003371, 28'h2006600, 28'h9007700,
        28'h1117041, 28'h2105400, 28'h8103041};

    always #5 core_clk = ~core_clk;

    d3i_ctrl_model ctrl (.core_clk(core_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .bank(bank), .addr(addr),
        .termination_input(termination_input));
    d3i_init_core #(.DLL_LOCK_CYC(4), .CAL_INIT_CYC(4)) uut (.core_clk(core_clk),
        .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank(bank), .addr(addr), .termination_input(termination_input),
        .termination_on_q(termination_on_q), .init_done_q(init_done_q),
        .mode_written_q(mode_written_q), .burst_latency_mode_q(mr0_q),
        .dll_drive_mode_q(mr1_q), .write_latency_mode_q(mr2_q),
        .extra_feature_mode_q(mr3_q), .dll_locked_q(dll_locked_q),
        .beat_valid_q(beat_valid_q), .beat_drive_q(beat_drive_q), .beat_index_q(beat_index_q));

    task check(input string what, input logic [14:0] seen, input logic [14:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Full init, then a bounded wait for ready
    task bring_up;
        int n;
        repeat (20) @(posedge core_clk);
        ctrl.init_seq(15'h0000, 15'h0104);
        n = 0;
        while (init_done_q !== 1'b1 && n < 200)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("init_done", 15'(init_done_q), 15'h0001);
        check("mode_zero", mr0_q, 15'h0004);
        check("mode_one", mr1_q, 15'h0000);
        check("mode_two", mr2_q, 15'h0008);
        check("mode_three", mr3_q, 15'h0003);
        check("written", 15'(mode_written_q), 15'h000f);
    endtask

    // Hang guard
    initial
    begin
        #20000;
        err_count++;
        final_report;
    end

    // Reset, power-up, burst table, warm reset
    initial
    begin
        repeat (8) @(posedge core_clk);
        #1;
        check("term_in_reset", 15'(termination_on_q), 15'h0000);
        rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check("term_before_cke", 15'(termination_on_q), 15'h0000);
        check("written_after_reset", 15'(mode_written_q), 15'h0000);
        bring_up;
        $display("test power up done");
        foreach (rows[i])
        begin
            r = rows[i];
            ctrl.cmd(4'h0, 3'h0, {11'h000, r[27:24]});
            ctrl.cmd(r[20] ? 4'h4 : 4'h5, 3'h0, {2'h0, r[16], 9'h000, r[14:12]});
            check("first_beat", 15'(beat_index_q), 15'(r[10:8]));
            repeat (4) @(posedge core_clk);
            #1;
            check("fifth_drive", 15'(beat_drive_q), 15'(r[0]));
            if (r[0])
                check("fifth_beat", 15'(beat_index_q), 15'(r[6:4]));
            check("mode_zero_row", mr0_q, {11'h000, r[27:24]});
            repeat (4) @(posedge core_clk);
        end
        $display("test burst order done");
        #1;
        ctrl.termination_input = 1'b1;
        @(posedge core_clk);
        #1;
        check("term_on", 15'(termination_on_q), 15'h0001);
        ctrl.termination_input = 1'b0;
        rst_n = 1'b0;
        ctrl.cke = 1'b0;
        repeat (10) @(posedge core_clk);
        #1;
        check("warm_done", 15'(init_done_q), 15'h0000);
        check("warm_written", 15'(mode_written_q), 15'h0000);
        rst_n = 1'b1;
        bring_up;
        $display("test warm reset done");
        final_report;
    end
endmodule
